// ===== design/lscb_params.svh
// Constants shared by both ends of the lane calibration burst link
`ifndef LSCB_PARAMS_SVH
`define LSCB_PARAMS_SVH

// ****************************************************************
// Clock and time
// ****************************************************************
`define LSCB_SYS_MHZ         25
`define LSCB_INIT_US         100
`define LSCB_CAL_MAX_INIT_US 100
`define LSCB_CAL_MAX_PER_US  10
`define LSCB_HALF_DIV        4

// ****************************************************************
// Pattern lengths in unit intervals and pattern bytes
// ****************************************************************
`define LSCB_SYNC_UI       16'h0010
`define LSCB_CAL_INIT_EXP  15
`define LSCB_CAL_PER_EXP   10
`define LSCB_CAL_LOCK      16
`define LSCB_CAL_SYNC_BYTE 8'hff
`define LSCB_LEADER        8'hb4

// ****************************************************************
// Low-power line codes and reset timing
// ****************************************************************
`define LSCB_LP_STOP   2'h3
`define LSCB_LP_HSRQ   2'h1
`define LSCB_LP_BRIDGE 2'h0
`define LSCB_LP_SLEEP  2'h0
`define LSCB_TIM_RST   8'h04

`endif

// ===== design/lscb_pkg.sv
// Types shared by both ends of the lane calibration burst link
package lscb_pkg;

	// Interval lengths for one data rate, in unit intervals
	typedef struct packed {
		logic [7:0] lpx;
		logic [7:0] prepare;
		logic [7:0] zero;
		logic [7:0] trail;
		logic [7:0] exit_t;
		logic [7:0] pre;
		logic [7:0] post;
		logic [7:0] skip;
	} lscb_tim_s;

	// Transmitter sequence, Gray from TX_IDLE to TX_POST along the calibration burst path
	typedef enum logic [3:0] {
		TX_INIT  = 4'h0,
		TX_IDLE  = 4'h1,
		TX_PRE   = 4'h3,
		TX_REQ   = 4'h2,
		TX_PREP  = 4'h6,
		TX_ZERO  = 4'h7,
		TX_SYNC  = 4'h5,
		TX_LOAD  = 4'h4,
		TX_TRAIL = 4'hc,
		TX_EXIT  = 4'hd,
		TX_POST  = 4'hf,
		TX_SLEEP = 4'he
	} lscb_txst_e;

	// Receiver data lane sequence
	typedef enum logic [3:0] {
		RX_INIT   = 4'h0,
		RX_STOP   = 4'h1,
		RX_REQ    = 4'h3,
		RX_BRIDGE = 4'h2,
		RX_SETTLE = 4'h6,
		RX_HUNT   = 4'h7,
		RX_CAL    = 4'h5,
		RX_DATA   = 4'h4,
		RX_TAIL   = 4'hc
	} lscb_rxst_e;

	// Clock lane states as seen by the receiver
	typedef enum logic [2:0] {
		CL_INIT  = 3'h0,
		CL_STOP  = 3'h1,
		CL_ENTRY = 3'h3,
		CL_HS    = 3'h2,
		CL_EXIT  = 3'h6,
		CL_SLEEP = 3'h5
	} lscb_clk_e;

endpackage : lscb_pkg

// ===== design/lscb_link_if.sv
// Wires of one data lane and its clock lane between the two ends
`timescale 1ns/1ns
interface lscb_link_if;
	logic [1:0] lp;     // Data lane low-power level, p in bit 1
	logic       hs_on;  // Fast driver enabled
	logic       hs_bit; // Fast differential bit
	logic       clk_hs; // Forwarded link clock
	logic [1:0] clk_lp; // Clock lane low-power level

	modport tx (
		output lp,
		output hs_on,
		output hs_bit,
		output clk_hs,
		output clk_lp
	);
	modport rx (
		input lp,
		input hs_on,
		input hs_bit,
		input clk_hs,
		input clk_lp
	);
endinterface : lscb_link_if

// ===== design/lscb_sync.sv
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/1ns
module lscb_sync #(
	parameter int W = 1
)(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} lscb_sync_s;

	lscb_sync_s r;
	lscb_sync_s next_r;

	// First stage feeds only the second stage
	always_comb begin
		next_r.meta = d;
		next_r.q    = r.meta;
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.q;
endmodule // lscb_sync

// ===== design/lscb_rx_end.sv
// Receiver end: burst detection, calibration, trailer trimming
`timescale 1ns/1ns
`include "lscb_params.svh"
module lscb_rx_end
	import lscb_pkg::*;
#(
	parameter int CAL_LOCK = `LSCB_CAL_LOCK
)(
	// Clock and reset
	input  wire logic      clk_sys,
	input  wire logic      rst_n,
	// Link from the transmitter
	lscb_link_if.rx        link,
	// Rate programming
	input  wire logic      rate_set,
	input  wire lscb_tim_s cfg_tim,
	output logic           rate_ack,
	// Received bytes
	output logic [7:0]     rx_data,
	output logic           rx_valid,
	output logic           burst_end,
	// Calibration and lane status
	output logic           cal_busy,
	output logic           cal_done,
	output logic           calib_ok,
	output logic           term_en,
	output lscb_clk_e      clk_state
);
	localparam int INIT_CYC = `LSCB_INIT_US * `LSCB_SYS_MHZ;
	localparam logic [11:0] INIT_TOP = 12'(INIT_CYC - 1);
	localparam logic [15:0] LOCK_TOP = 16'(CAL_LOCK - 1);

	typedef struct packed {
		lscb_rxst_e st;
		lscb_clk_e  cst;
		lscb_tim_s  tim;
		logic [11:0] tcnt;
		logic [15:0] cnt;
		logic [7:0]  hist;
		logic [7:0]  cur_b;
		logic [2:0]  bit_n;
		logic [7:0]  pend;
		logic        pend_v;
		logic [7:0]  conf;
		logic        arm;
		logic        prev;
		logic        clk_d;
		logic        term;
		logic        busy;
		logic        calib;
		logic [7:0]  data;
		logic        valid;
		logic        done;
		logic        bend;
		logic        ack;
	} lscb_rx_s;

	lscb_rx_s   r;
	lscb_rx_s   next_r;
	logic [6:0] sv;
	logic [1:0] s_lp;
	logic       s_bit;
	logic       s_clk;
	logic [1:0] s_clp;
	logic       rise;
	logic [7:0] shifted;

	// ****************************************************************
	// Input crossing
	// ****************************************************************
	lscb_sync #(.W(7)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       ({link.clk_lp, link.clk_hs, link.hs_bit,
		           link.hs_on, link.lp}),
		.q       (sv)
	);
	assign s_lp    = sv[1:0];
	assign s_bit   = sv[3];
	assign s_clk   = sv[4];
	assign s_clp   = sv[6:5];
	assign rise    = s_clk & ~r.clk_d;
	assign shifted = {r.hist[6:0], s_bit};

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_r       = r;
		next_r.clk_d = s_clk;
		next_r.valid = 1'b0;
		next_r.done  = 1'b0;
		next_r.bend  = 1'b0;
		next_r.ack   = 1'b0;
		if (rise) begin
			next_r.prev = s_bit;
		end
		case (r.st)
			RX_INIT: begin
				next_r.tcnt = r.tcnt + 12'h001;
				if (s_lp != `LSCB_LP_STOP) begin
					next_r.tcnt = '0;
				end else if (r.tcnt == INIT_TOP) begin
					next_r.st = RX_STOP;
				end
			end
			RX_STOP: if (s_lp == `LSCB_LP_HSRQ) begin
				next_r.st = RX_REQ;
			end
			RX_REQ: begin
				if (s_lp == `LSCB_LP_BRIDGE) begin
					next_r.st  = RX_BRIDGE;
					next_r.cnt = '0;
				end else if (s_lp == `LSCB_LP_STOP) begin
					next_r.st = RX_STOP;
				end
			end
			RX_BRIDGE: if (rise) begin
				next_r.cnt = r.cnt + 16'h0001;
				if (r.cnt[7:0] == r.tim.prepare) begin
					next_r.term = 1'b1; // Termination on
					next_r.st   = RX_SETTLE;
					next_r.cnt  = '0;
				end
			end
			RX_SETTLE: if (rise) begin
				next_r.cnt = r.cnt + 16'h0001;
				if (r.cnt[7:0] == r.tim.zero) begin
					next_r.st   = RX_HUNT;
					next_r.hist = '0;
				end
			end
			RX_HUNT: if (rise) begin
				next_r.hist = shifted;
				if (shifted == `LSCB_CAL_SYNC_BYTE) begin
					next_r.st   = RX_CAL;
					next_r.busy = 1'b1;
					next_r.cnt  = '0;
				end else if (shifted == `LSCB_LEADER) begin
					next_r.st     = RX_DATA;
					next_r.bit_n  = '0;
					next_r.pend_v = 1'b0;
					next_r.arm    = 1'b0;
				end
			end
			RX_CAL: if (rise && r.busy) begin
				// Any repeated bit restarts the lock count
				if (s_bit == r.prev) begin
					next_r.cnt = '0;
				end else if (r.cnt == LOCK_TOP) begin
					next_r.busy  = 1'b0; // Done inside the pattern
					next_r.calib = 1'b1;
					next_r.done  = 1'b1;
				end else begin
					next_r.cnt = r.cnt + 16'h0001;
				end
			end
			RX_DATA: if (rise) begin
				next_r.cur_b = {r.cur_b[6:0], s_bit};
				next_r.bit_n = r.bit_n + 3'h1;
				if (r.bit_n == 3'h7) begin
					// Older byte is data once a newer one completes
					next_r.valid  = r.pend_v;
					next_r.data   = r.pend;
					next_r.pend   = {r.cur_b[6:0], s_bit};
					next_r.pend_v = 1'b1;
					next_r.arm    = 1'b0;
				end else if (s_bit != r.prev && r.pend_v) begin
					next_r.arm  = 1'b1; // Last transition seen
					next_r.conf = r.tim.skip;
				end else if (r.arm) begin
					next_r.conf = r.conf - 8'h01;
					if (r.conf == 8'h00) begin
						next_r.arm    = 1'b0; // Past skip window
						next_r.valid  = 1'b1;
						next_r.data   = r.pend;
						next_r.pend_v = 1'b0;
					end
				end
			end
			RX_TAIL: begin
				// Unconfirmed byte and partial bits are trailer
				next_r.pend_v = 1'b0;
				next_r.arm    = 1'b0;
				next_r.busy   = 1'b0;
				next_r.st     = RX_STOP; // Leader hunt rearmed
			end
			default: next_r.st = RX_INIT;
		endcase
		// Stop state after the bridge ends the burst
		if ((r.st == RX_BRIDGE || r.st == RX_SETTLE || r.st == RX_HUNT ||
		     r.st == RX_CAL || r.st == RX_DATA) &&
		    s_lp == `LSCB_LP_STOP) begin
			next_r.st   = RX_TAIL;
			next_r.term = 1'b0;
			next_r.bend = 1'b1;
		end
		// Rate reload only while idle and clock halted
		if (rate_set && (r.st == RX_INIT || r.st == RX_STOP) &&
		    (r.cst == CL_INIT || r.cst == CL_STOP || r.cst == CL_SLEEP))
		begin
			next_r.tim   = cfg_tim;
			next_r.calib = 1'b0;
			next_r.ack   = 1'b1;
		end
		// Clock lane tracking
		case (r.cst)
			CL_INIT: if (r.st == RX_STOP) begin
				next_r.cst = CL_STOP;
			end
			CL_STOP: if (s_clp == `LSCB_LP_BRIDGE) begin
				next_r.cst = (s_lp == `LSCB_LP_SLEEP) ? CL_SLEEP : CL_ENTRY;
			end
			CL_ENTRY: if (rise) begin
				next_r.cst = CL_HS;
			end
			CL_HS: if (s_clp == `LSCB_LP_STOP) begin
				next_r.cst = CL_EXIT;
			end
			CL_EXIT: next_r.cst = CL_STOP;
			CL_SLEEP: if (s_clp == `LSCB_LP_STOP) begin
				next_r.cst = CL_STOP;
			end
			default: next_r.cst = CL_INIT;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r     <= '0;
			r.tim <= '{default: `LSCB_TIM_RST};
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state
	assign rate_ack  = r.ack;
	assign rx_data   = r.data;
	assign rx_valid  = r.valid;
	assign burst_end = r.bend;
	assign cal_busy  = r.busy;
	assign cal_done  = r.done;
	assign calib_ok  = r.calib;
	assign term_en   = r.term;
	assign clk_state = r.cst;
endmodule // lscb_rx_end

// ===== design/lscb_tx_end.sv
// Transmitter end: burst sequencing, calibration pattern, clocking
//
// Summary of operation
// - Flip last bit, hold for trailer time
// - After trailer, slow driver drives stop
// - Receiver sees stop, drops termination
// - Receiver discards bits of skip window
// - Receiver trims trailer after last transition
// - Receiver rearms leader hunt after burst
// - Receiver calibrates in pattern; sender never waits
// - Pattern capped at 100 or 10 us
// - Sixteen UI of ones precede pattern
// - Pattern at least 2^15 or 2^10 UI unless the time cap ends it first
// - Periodic calibration waits for burst end
// - Rate constant through a whole burst
// - Rate changes only idle, asleep or init
// - Pre clock cycles before any data
// - Bridge for prepare, then zero interval
// - Clock runs post interval after data
// - Cycle counts reloaded on rate change
// - Clock lane has four main states
// - Receiver starts calibration on sync pattern
// - Fast rate needs initial calibration first
`timescale 1ns/1ns
`include "lscb_params.svh"
module lscb_tx_end
	import lscb_pkg::*;
#(
	parameter int HALF_DIV    = `LSCB_HALF_DIV,
	parameter int MIN_UI_INIT = 1 << `LSCB_CAL_INIT_EXP,
	parameter int MIN_UI_PER  = 1 << `LSCB_CAL_PER_EXP
)(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Link towards the receiver
	lscb_link_if.tx          link,
	// Calibration requests
	input  wire logic        cal_req,
	input  wire logic        cal_periodic,
	input  wire logic [15:0] cal_len,
	// Rate programming
	input  wire logic        rate_set,
	input  wire logic        rate_high,
	input  wire lscb_tim_s   cfg_tim,
	output logic             rate_ack,
	// Byte stream
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	// Power and status
	input  wire logic        sleep_req,
	output logic             tx_busy,
	output logic             calib_ok
);
	// ****************************************************************
	// Derived counts
	// ****************************************************************
	localparam int INIT_CYC = `LSCB_INIT_US * `LSCB_SYS_MHZ;
	localparam int MAXI_CYC = `LSCB_CAL_MAX_INIT_US * `LSCB_SYS_MHZ;
	localparam int MAXP_CYC = `LSCB_CAL_MAX_PER_US * `LSCB_SYS_MHZ;
	localparam logic [11:0] INIT_TOP = 12'(INIT_CYC - 1);
	localparam logic [11:0] MAXI_TOP = 12'(MAXI_CYC - 1);
	localparam logic [11:0] MAXP_TOP = 12'(MAXP_CYC - 1);
	localparam logic [15:0] MINI     = 16'(MIN_UI_INIT);
	localparam logic [15:0] MINP     = 16'(MIN_UI_PER);
	localparam logic [7:0]  DIV_TOP  = 8'(HALF_DIV - 1);
	localparam logic [7:0]  LEADER   = `LSCB_LEADER;

	typedef struct packed {
		lscb_txst_e  st;
		lscb_tim_s   tim;
		logic [7:0]  div;
		logic        ph;
		logic        clk_run;
		logic        clk_o;
		logic [15:0] cnt;
		logic [11:0] tcnt;
		logic [7:0]  sh;
		logic [2:0]  bit_n;
		logic        kind;
		logic        per;
		logic        init_pend;
		logic        per_pend;
		logic        high;
		logic        calib;
		logic        hs_on;
		logic        hs_bit;
		logic [1:0]  lp;
		logic [1:0]  clk_lp;
		logic        ack;
	} lscb_tx_s;

	lscb_tx_s    r;
	lscb_tx_s    next_r;
	logic        fall;
	logic        done;
	logic        need_init;
	logic [15:0] pat_min;
	logic [15:0] pat_len;
	logic [11:0] max_top;

	// ****************************************************************
	// Link clock divider and interval helpers
	// ****************************************************************
	// Bits launch on the falling edge so the far end samples mid-bit
	assign fall      = (r.div == DIV_TOP) && r.ph;
	assign done      = fall && (r.cnt == 16'h0000);
	assign need_init = r.init_pend | (r.high & ~r.calib);
	assign pat_min   = r.per ? MINP : MINI;
	assign pat_len   = (cal_len > pat_min) ? cal_len : pat_min;
	assign max_top   = r.per ? MAXP_TOP : MAXI_TOP;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_r     = r;
		next_r.ack = 1'b0;
		tx_ready   = 1'b0;
		// Divider runs always; only clk_run shows it on the pin
		if (r.div == DIV_TOP) begin
			next_r.div = '0;
			next_r.ph  = ~r.ph;
		end else begin
			next_r.div = r.div + 8'h01;
		end
		// Shared interval countdown, one step per unit interval
		if (fall && r.cnt != 16'h0000) begin
			next_r.cnt = r.cnt - 16'h0001;
		end
		case (r.st)
			TX_INIT: begin
				next_r.tcnt = r.tcnt + 12'h001;
				if (r.tcnt == INIT_TOP) begin
					next_r.st   = TX_IDLE;
					next_r.tcnt = '0;
				end
			end
			TX_IDLE: begin
				if (sleep_req) begin
					next_r.st     = TX_SLEEP;
					next_r.lp     = `LSCB_LP_SLEEP;
					next_r.clk_lp = `LSCB_LP_SLEEP;
				end else if ((need_init || r.per_pend || tx_valid) &&
				             r.div == DIV_TOP && !r.ph) begin
					// Idle only, at a clock phase edge: no runt pulse
					next_r.st      = TX_PRE;
					next_r.kind    = need_init | r.per_pend;
					next_r.per     = ~need_init & r.per_pend;
					next_r.clk_run = 1'b1;
					next_r.clk_lp  = `LSCB_LP_BRIDGE;
					next_r.cnt     = {8'h00, r.tim.pre};
				end
			end
			TX_SLEEP: if (!sleep_req) begin
				next_r.st     = TX_IDLE;
				next_r.lp     = `LSCB_LP_STOP;
				next_r.clk_lp = `LSCB_LP_STOP;
			end
			TX_PRE: if (done) begin
				next_r.st  = TX_REQ; // Pre clocks sent
				next_r.lp  = `LSCB_LP_HSRQ;
				next_r.cnt = {8'h00, r.tim.lpx};
			end
			TX_REQ: if (done) begin
				next_r.st  = TX_PREP;
				next_r.lp  = `LSCB_LP_BRIDGE;
				next_r.cnt = {8'h00, r.tim.prepare};
			end
			TX_PREP: if (done) begin
				next_r.st     = TX_ZERO;
				next_r.hs_on  = 1'b1;
				next_r.hs_bit = 1'b0;
				next_r.cnt    = {8'h00, r.tim.zero};
			end
			TX_ZERO: if (done) begin
				if (r.kind) begin
					next_r.st     = TX_SYNC;
					next_r.hs_bit = 1'b1;
					next_r.cnt    = `LSCB_SYNC_UI - 16'h0001;
				end else begin
					next_r.st     = TX_LOAD;
					next_r.hs_bit = LEADER[7];
					next_r.sh     = {LEADER[6:0], 1'b0};
					next_r.bit_n  = 3'h7;
				end
			end
			TX_SYNC: if (done) begin
				next_r.st     = TX_LOAD;
				next_r.hs_bit = 1'b0;
				next_r.cnt    = pat_len - 16'h0001;
				next_r.tcnt   = '0;
			end
			TX_LOAD: begin
				if (r.kind) begin
					// Alternating pattern; no wait for the far end
					next_r.tcnt = r.tcnt + 12'h001;
					if (fall) begin
						next_r.hs_bit = ~r.hs_bit;
						if (r.cnt == 16'h0000 || r.tcnt >= max_top) begin
							next_r.st  = TX_TRAIL; // Length done or capped time
							next_r.cnt = {8'h00, r.tim.trail};
						end
					end
				end else if (fall) begin
					if (r.bit_n != 3'h0) begin
						next_r.hs_bit = r.sh[7];
						next_r.sh     = {r.sh[6:0], 1'b0};
						next_r.bit_n  = r.bit_n - 3'h1;
					end else begin
						tx_ready = 1'b1;
						if (tx_valid) begin
							next_r.hs_bit = tx_data[7];
							next_r.sh     = {tx_data[6:0], 1'b0};
							next_r.bit_n  = 3'h7;
						end else begin
							next_r.st     = TX_TRAIL;
							next_r.hs_bit = ~r.hs_bit;
							next_r.cnt    = {8'h00, r.tim.trail};
						end
					end
				end
			end
			TX_TRAIL: if (done) begin
				next_r.st    = TX_EXIT; // Trailer held, now stop
				next_r.hs_on = 1'b0;
				next_r.lp    = `LSCB_LP_STOP;
				next_r.cnt   = {8'h00, r.tim.exit_t};
			end
			TX_EXIT: if (done) begin
				next_r.st  = TX_POST;
				next_r.cnt = {8'h00, r.tim.post};
			end
			TX_POST: if (done) begin
				next_r.st      = TX_IDLE; // Post clocks sent
				next_r.clk_run = 1'b0;
				next_r.clk_lp  = `LSCB_LP_STOP;
				if (r.kind && r.per) begin
					next_r.per_pend = 1'b0;
				end else if (r.kind) begin
					next_r.init_pend = 1'b0;
					next_r.calib     = 1'b1;
				end
			end
			default: next_r.st = TX_INIT;
		endcase
		// New requests win over a clear in the same cycle
		if (cal_req && cal_periodic) begin
			next_r.per_pend = 1'b1;
		end else if (cal_req) begin
			next_r.init_pend = 1'b1;
		end
		// Rate reload only with the clock halted
		if (rate_set && (r.st == TX_INIT || r.st == TX_IDLE ||
		                 r.st == TX_SLEEP)) begin
			next_r.tim   = cfg_tim;
			next_r.high  = rate_high;
			next_r.calib = 1'b0;
			next_r.ack   = 1'b1;
		end
		next_r.clk_o = next_r.ph & next_r.clk_run;
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r        <= '0;
			r.tim    <= '{default: `LSCB_TIM_RST};
			r.lp     <= `LSCB_LP_STOP;
			r.clk_lp <= `LSCB_LP_STOP;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign link.lp     = r.lp;
	assign link.hs_on  = r.hs_on;
	assign link.hs_bit = r.hs_bit;
	assign link.clk_hs = r.clk_o;
	assign link.clk_lp = r.clk_lp;
	assign rate_ack    = r.ack;
	assign calib_ok    = r.calib;
	assign tx_busy     = (r.st != TX_IDLE) && (r.st != TX_SLEEP);
endmodule // lscb_tx_end

// ===== verif/lscb_link_properties.sv
// Wire checks between the two lane ends
`timescale 1ns/1ns
`include "lscb_params.svh"
module lscb_link_properties (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// Lane wires
	input wire logic [1:0] lp,
	input wire logic       hs_on,
	input wire logic       hs_bit,
	input wire logic       clk_hs,
	input wire logic [1:0] clk_lp
);
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Trailer bit is the inverse of the last bit and holds until exit
	a_trail_flip: assert property (
		$fell(hs_on) |-> $past(hs_bit) != $past(hs_bit, 40)
		&& $past(hs_bit) == $past(hs_bit, 24))
		else $error("trailer not flipped or not held");
	a_exit_stop: assert property (
		$fell(hs_on) |-> (lp == `LSCB_LP_STOP && !hs_on)[*8])
		else $error("stop level not held after fast driver off");
	a_fast_bridge: assert property (
		hs_on |-> lp == `LSCB_LP_BRIDGE)
		else $error("low-power level not bridge while fast");
	a_prep_lead: assert property (
		$rose(hs_on) |-> $past(lp, 8) == `LSCB_LP_BRIDGE)
		else $error("bridge too short before fast driver");
	a_zero_lead: assert property (
		$rose(hs_on) |-> (!hs_bit)[*8])
		else $error("fast zero too short");
	// Half period fixed by the divider, so the rate never drifts
	a_clock_half: assert property (
		$rose(clk_hs) |-> clk_hs[*4] ##1 !clk_hs)
		else $error("link clock half period wrong");
	a_bit_launch: assert property (
		hs_on && $changed(hs_bit) |-> $fell(clk_hs))
		else $error("fast bit changed off the falling edge");
	a_clock_lead: assert property (
		$fell(lp[1]) |-> clk_lp == 2'h0 && $past(clk_lp, 8) == 2'h0)
		else $error("clock not running before request");
	a_clock_tail: assert property (
		$fell(hs_on) |-> (clk_lp == 2'h0)[*8] ##[1:8] $rose(clk_hs))
		else $error("clock stopped before tail time");

	// Main scenarios
	c_burst_start: cover property ($rose(hs_on));
	c_burst_end: cover property ($fell(hs_on));
	c_request: cover property ($fell(lp[1]));
endmodule // lscb_link_properties

// ===== verif/tb_top.sv
// Bench joining both lane ends across the link interface
`timescale 1ns/1ns
module tb_top
	import lscb_pkg::*;
;
	// ********************
	// Signals
	// ********************
	typedef struct {
		logic [15:0] d;
		int          n;
		logic [15:0] exp;
	} lscb_row_s;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        cal_req = 1'b0;
	logic        cal_periodic = 1'b0;
	logic [15:0] cal_len = 16'h0064;
	logic        rate_set = 1'b0;
	logic        rate_high = 1'b1;
	logic        sleep_req = 1'b0;
	logic [7:0]  tx_data = 8'h00;
	logic        tx_valid = 1'b0;
	lscb_tim_s   cfg_tim = 64'h0404_0603_0404_0402; // Trail 4 UI, skip 3
	logic        tx_ack, rx_ack, tx_ready, tx_busy, tx_cal_ok, rx_valid;
	logic        burst_end, cal_busy, cal_done, rx_cal_ok, term_en;
	logic [7:0]  rx_data;
	lscb_clk_e   clk_state;
	int          num_errors = 0;
	int          checks = 0;
	// Single bursts first, then a two byte one
	lscb_row_s   rows [5] = '{
		'{16'h0000, 1, 16'h0000}, '{16'hff00, 1, 16'h00ff},
		'{16'hb400, 1, 16'h00b4}, '{16'h8000, 1, 16'h0080},
		'{16'h0155, 2, 16'h0155}};

	// ********************
	// Ends and checker
	// ********************
	lscb_link_if link ();
	lscb_tx_end #(.HALF_DIV(4), .MIN_UI_INIT(64), .MIN_UI_PER(32))
	u_lscb_tx_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
		.cal_req(cal_req), .cal_periodic(cal_periodic), .cal_len(cal_len),
		.rate_set(rate_set), .rate_high(rate_high), .cfg_tim(cfg_tim),
		.rate_ack(tx_ack), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .sleep_req(sleep_req), .tx_busy(tx_busy),
		.calib_ok(tx_cal_ok));
	lscb_rx_end #(.CAL_LOCK(16)) u_lscb_rx_end (.clk_sys(clk_sys),
		.rst_n(rst_n), .link(link), .rate_set(rate_set), .cfg_tim(cfg_tim),
		.rate_ack(rx_ack), .rx_data(rx_data), .rx_valid(rx_valid),
		.burst_end(burst_end), .cal_busy(cal_busy), .cal_done(cal_done),
		.calib_ok(rx_cal_ok), .term_en(term_en), .clk_state(clk_state));
	lscb_link_properties u_lscb_link_properties (.clk_sys(clk_sys),
		.rst_n(rst_n), .lp(link.lp), .hs_on(link.hs_on),
		.hs_bit(link.hs_bit), .clk_hs(link.clk_hs), .clk_lp(link.clk_lp));

	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;

	// ********************
	// Compare and report
	// ********************
	task automatic fail(input string what);
		num_errors++;
		$display("unexpected at %0t: %s", $time, what);
	endtask
	task automatic chk_bit(input logic got, exp, input string what);
		checks++;
		if (got !== exp) fail(what);
	endtask
	task automatic chk_word(input logic [15:0] got, exp, input string what);
		checks++;
		if (got !== exp) fail(what);
	endtask
	task automatic chk_state(input lscb_clk_e got, exp, input string what);
		checks++;
		if (got !== exp) fail(what);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ********************
	// Drivers, all at the falling edge
	// ********************
	task automatic pulse_rate(output logic ta, ra);
		@(negedge clk_sys);
		rate_set = 1'b1;
		@(negedge clk_sys);
		rate_set = 1'b0;
		ta = tx_ack;
		ra = rx_ack;
	endtask
	task automatic cal(input logic periodic, input logic [15:0] len);
		@(negedge clk_sys);
		cal_req = 1'b1;
		cal_periodic = periodic;
		cal_len = len;
		@(negedge clk_sys);
		cal_req = 1'b0;
	endtask
	// Valid held until each fetch slot takes a byte; low ends the burst
	task automatic send(input logic [15:0] bytes, input int n);
		int i;
		i = 0;
		tx_data = bytes[15:8];
		tx_valid = 1'b1;
		for (int k = 0; k < 6000 && i < n; k++) begin
			@(negedge clk_sys);
			if (tx_ready === 1'b1) begin
				i++;
				@(negedge clk_sys);
				tx_data = bytes[7:0];
				tx_valid = (i < n);
			end
		end
	endtask
	// Gathers bytes until the receiver reports the burst end
	task automatic collect(output logic [15:0] got, output int cnt);
		got = 16'h0000;
		cnt = 0;
		for (int k = 0; k < 6000; k++) begin
			@(negedge clk_sys);
			if (rx_valid === 1'b1) begin
				got = {got[7:0], rx_data};
				cnt++;
			end
			if (burst_end === 1'b1) break;
		end
	endtask
	// Bounded wait: 0 lock pulse, 1 tx calibrated, 2 tx idle
	task automatic wait_sig(input int s, output logic seen);
		seen = 1'b0;
		for (int k = 0; k < 4000 && !seen; k++) begin
			@(negedge clk_sys);
			case (s)
				0: seen = (cal_done === 1'b1);
				1: seen = (tx_cal_ok === 1'b1);
				default: seen = (tx_busy === 1'b0);
			endcase
		end
	endtask
	task automatic check_reset();
		rst_n = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk_word({14'h0000, link.lp}, 16'h0003, "lane level");
		chk_word({14'h0000, link.clk_lp}, 16'h0003, "clock lane");
		chk_bit(link.hs_on, 1'b0, "fast driver");
		chk_bit(term_en, 1'b0, "termination");
		chk_bit(rx_cal_ok, 1'b0, "rx calibrated");
		chk_state(clk_state, CL_INIT, "clock lane state");
		rst_n = 1'b1;
		$display("test reset done");
	endtask

	// ********************
	// Sequence
	// ********************
	initial begin : main
		logic seen, ta, ra;
		logic [15:0] got;
		int cnt;
		check_reset();
		pulse_rate(ta, ra);
		chk_bit(ta, 1'b1, "tx rate ack in init");
		chk_bit(ra, 1'b1, "rx rate ack in init");
		wait_sig(2, seen);
		cal(1'b0, 16'h0064);
		wait_sig(0, seen);
		chk_bit(seen, 1'b1, "lock pulse");
		chk_bit(cal_busy, 1'b0, "busy ends with lock");
		chk_bit(term_en, 1'b1, "termination on");
		chk_bit(rx_cal_ok, 1'b1, "rx locked");
		wait_sig(1, seen);
		chk_bit(seen, 1'b1, "tx calibrated");
		$display("test initial calibration done");
		foreach (rows[i]) begin
			fork
				send(rows[i].d, rows[i].n);
				collect(got, cnt);
			join
			chk_word(got, rows[i].exp, "burst bytes");
			chk_word(16'(cnt), 16'(rows[i].n), "byte count");
			chk_bit(term_en, 1'b0, "termination at end");
			repeat (120) @(negedge clk_sys);
			chk_state(clk_state, CL_STOP, "clock lane stop");
			$display("test burst %0d done", i);
		end
		// Periodic request and rate change while a burst runs
		fork
			send(16'h5aa5, 2);
			collect(got, cnt);
			begin
				repeat (200) @(negedge clk_sys);
				cal(1'b1, 16'h0028);
				pulse_rate(ta, ra);
			end
		join
		chk_word(got, 16'h5aa5, "burst kept whole");
		chk_bit(ta, 1'b0, "tx rate change refused");
		chk_bit(ra, 1'b0, "rx rate change refused");
		wait_sig(0, seen);
		chk_bit(seen, 1'b1, "periodic lock after burst");
		wait_sig(2, seen);
		repeat (8) @(negedge clk_sys);
		pulse_rate(ta, ra);
		chk_bit(ta, 1'b1, "tx rate ack at stop");
		chk_bit(ra, 1'b1, "rx rate ack at stop");
		chk_bit(tx_cal_ok, 1'b0, "tx needs recalibration");
		chk_bit(rx_cal_ok, 1'b0, "rx needs recalibration");
		$display("test refused rate change done");
		// New fast rate: calibration burst goes out before the data
		fork
			send(16'h3c00, 1);
			begin
				collect(got, cnt);
				chk_word(16'(cnt), 16'h0000, "no data in pattern");
				chk_bit(rx_cal_ok, 1'b1, "recalibrated first");
				collect(got, cnt);
			end
		join
		chk_word(got, 16'h003c, "data after pattern");
		$display("test forced calibration done");
		check_reset();
		report_and_stop();
	end

	// Whole run needs about 9000 cycles
	initial begin : watchdog
		repeat (40000) @(posedge clk_sys);
		num_errors++;
		report_and_stop();
	end
endmodule // tb_top
